// *** logic/cpu_ctl_pins.sv ***
// Processor control-pin logic: bus grant, interrupts, coprocessor
// handshake and reset entry, all on one system clock.
// Assumes the core supplies instruction and bus-boundary strobes on clk_i
// and that external buffers resolve the output enables to pin levels.
//
// Function
// - Float bus drivers before raising grant acknowledge
// - Keep grant while requested, then reclaim bus
// - Grant request is asynchronous, active high
// - Grant acknowledge is always actively driven
// - Maskable request ignored with interrupt flag clear
// - Two acknowledge cycles fetch 8-bit vector
// - Sample request each processor cycle, two ahead
// - Maskable request is asynchronous level, active high
// - Non-maskable uses vector two, no acknowledges
// - Interrupt flag does not affect non-maskable
// - Synchronise non-maskable input, then detect rise
// - Operand request answered by transfer with acknowledge
// - Operand acknowledge low-active, floats high during grant
// - Busy stalls coprocessor waits; interrupts still taken
// - Error during coprocessor wait raises extension interrupt
// - Busy and error are asynchronous, active low
// - Reset high over sixteen clocks reinitialises
// - Defined pin levels while reset is active
// - About fifty clocks initialisation before first fetch
// - Ready ignored while bus is granted
module cpu_ctl_pins (
  // Clock and block reset
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  // Pins from the system
  input  wire logic                  reset_pin_i,
  input  wire logic                  bus_grant_request_i,
  input  wire logic                  maskable_irq_i,
  input  wire logic                  nonmaskable_irq_i,
  input  wire logic                  ext_operand_req_i,
  input  wire logic                  coproc_stall_n_i,
  input  wire logic                  coproc_fault_n_i,
  input  wire logic                  ready_n_i,
  input  wire logic [15:0]           data_lines_i,
  // Requests from the execution core
  input  wire logic                  if_flag_i,
  input  wire logic                  instr_end_i,
  input  wire logic                  bus_boundary_i,
  input  wire logic                  lock_seq_i,
  input  wire logic                  coproc_wait_i,
  input  wire logic [23:0]           opnd_addr_i,
  // Pins to the system
  output logic                       bus_grant_ack_o,
  output cpu_ctl_pkg::pin_out_t      pins_o,
  output logic                       bus_oe_o,
  output logic                       ext_operand_ack_oe_o,
  output logic                       data_oe_o,
  // Answers to the execution core
  output logic                       core_reset_o,
  output logic                       fetch_start_o,
  output logic                       exec_stall_o,
  output logic                       ext_fault_o,
  output logic                       int_take_o,
  output logic [7:0]                 int_vector_o,
  output logic                       opnd_done_o
);
  import cpu_ctl_pkg::*;

  logic [SY_W-1:0] sync1_r;
  logic [SY_W-1:0] sync2_r;
  logic [15:0]     data1_r;
  logic [15:0]     data2_r;
  logic [SY_W-1:0] pin_raw;
  logic            proc_div_r;
  logic            proc_en;
  logic [4:0]      rst_cnt_r;
  logic            in_reset_r;
  logic [5:0]      init_cnt_r;
  logic            nmi_old_r;
  logic            nmi_pend_r;
  logic            maskable_irq_smp_r;
  logic            maskable_irq_old_r;
  logic            maskable_irq_go_r;
  logic            take_point;
  logic            ready_s;
  bus_state_t      st_r;
  bus_state_t      st_nxt;
  // Gather the asynchronous pins into one vector
  assign pin_raw = {reset_pin_i, ready_n_i, coproc_fault_n_i,
                    coproc_stall_n_i, ext_operand_req_i,
                    nonmaskable_irq_i, maskable_irq_i, bus_grant_request_i};
  // Two flops per pin; the first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < SY_W; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
          sync1_r[g] <= SYNC_RST[g];
          sync2_r[g] <= SYNC_RST[g];
        end else begin
          sync1_r[g] <= pin_raw[g];
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate
  // Data lines are sampled through two stages, aligned with ready
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      data1_r <= 16'h0000;
      data2_r <= 16'h0000;
    end else begin
      data1_r <= data_lines_i;
      data2_r <= data1_r;
    end
  end
  assign ready_s = !sync2_r[SY_RDYN];
  // Processor-cycle enable: one pulse every two clocks
  always_ff @(posedge clk_i) begin
    if (!nrst_i || in_reset_r) begin
      proc_div_r <= 1'b0;
    end else begin
      proc_div_r <= !proc_div_r;
    end
  end
  assign proc_en = (proc_div_r == PROC_DIV_END);
  // Reset pin must stay high for more than the hold count
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rst_cnt_r  <= 5'h00;
      in_reset_r <= 1'b1;
    end else if (sync2_r[SY_RESET]) begin
      if (rst_cnt_r != RESET_HOLD_CNT) begin
        rst_cnt_r <= rst_cnt_r + 5'h01;
      end else begin
        in_reset_r <= 1'b1;
      end
    end else begin
      rst_cnt_r  <= 5'h00;
      in_reset_r <= 1'b0;
    end
  end
  // Initialisation delay before the first code fetch
  always_ff @(posedge clk_i) begin
    if (!nrst_i || in_reset_r) begin
      init_cnt_r    <= 6'h00;
      fetch_start_o <= 1'b0;
    end else begin
      fetch_start_o <= (st_r == BS_INIT) &&
                       (init_cnt_r == INIT_CNT - 6'h01);
      if (st_r == BS_INIT) begin
        init_cnt_r <= init_cnt_r + 6'h01;
      end
    end
  end

  // Non-maskable request: edge after synchronisation, flag ignored
  always_ff @(posedge clk_i) begin
    if (!nrst_i || in_reset_r) begin
      nmi_old_r  <= 1'b0;
      nmi_pend_r <= 1'b0;
    end else begin
      nmi_old_r <= sync2_r[SY_NMI];
      if (sync2_r[SY_NMI] && !nmi_old_r) begin
        nmi_pend_r <= 1'b1;
      end else if (take_point) begin
        nmi_pend_r <= 1'b0;
      end
    end
  end
  // Interrupts are taken at an instruction end or while stalled
  assign take_point = instr_end_i || exec_stall_o;
  // Maskable request sampled at each processor cycle start
  always_ff @(posedge clk_i) begin
    if (!nrst_i || in_reset_r) begin
      maskable_irq_smp_r <= 1'b0;
      maskable_irq_old_r <= 1'b0;
    end else if (proc_en) begin
      maskable_irq_smp_r <= sync2_r[SY_MASKABLE_IRQ];
      maskable_irq_old_r <= maskable_irq_smp_r;
    end
  end
  // A level seen two processor cycles back qualifies at the take point
  always_ff @(posedge clk_i) begin
    if (!nrst_i || in_reset_r) begin
      maskable_irq_go_r <= 1'b0;
    end else if (take_point && !nmi_pend_r && if_flag_i &&
                 maskable_irq_old_r && maskable_irq_smp_r) begin
      maskable_irq_go_r <= 1'b1;
    end else if (st_r == BS_ACK1) begin
      maskable_irq_go_r <= 1'b0;
    end
  end
  // Bus sequencer: grant, acknowledge pair and operand transfer
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      BS_INIT: begin
        if (fetch_start_o) begin
          st_nxt = BS_IDLE;
        end
      end
      BS_IDLE: begin
        if (sync2_r[SY_HOLD] && bus_boundary_i && !lock_seq_i) begin
          st_nxt = BS_FLOAT;
        end else if (maskable_irq_go_r) begin
          st_nxt = BS_ACK1;
        end else if (sync2_r[SY_OPREQ]) begin
          st_nxt = BS_OPND;
        end
      end
      BS_FLOAT: begin
        st_nxt = BS_GRANT;
      end
      BS_GRANT: begin
        if (!sync2_r[SY_HOLD]) begin
          st_nxt = BS_IDLE;
        end
      end
      BS_ACK1: begin
        if (ready_s) begin
          st_nxt = BS_ACK2;
        end
      end
      BS_ACK2, BS_OPND: begin
        if (ready_s) begin
          st_nxt = BS_IDLE;
        end
      end
      default: begin
        st_nxt = BS_IDLE;
      end
    endcase
  end
  // State register and core reset, both held while reset is active
  always_ff @(posedge clk_i) begin
    if (!nrst_i || in_reset_r) begin
      st_r         <= BS_INIT;
      core_reset_o <= 1'b1;
    end else begin
      st_r         <= st_nxt;
      core_reset_o <= 1'b0;
    end
  end
  // Grant acknowledge is a plain driven output, never floated
  always_ff @(posedge clk_i) begin
    if (!nrst_i || in_reset_r) begin
      bus_grant_ack_o <= 1'b0;
    end else begin
      bus_grant_ack_o <= (st_nxt == BS_GRANT);
    end
  end
  // Drivers float one cycle ahead of the acknowledge
  always_ff @(posedge clk_i) begin
    if (!nrst_i || in_reset_r) begin
      bus_oe_o             <= 1'b1;
      ext_operand_ack_oe_o <= 1'b1;
      data_oe_o            <= 1'b0;
    end else begin
      bus_oe_o             <= !(st_nxt inside {BS_FLOAT, BS_GRANT});
      ext_operand_ack_oe_o <= !(st_nxt inside {BS_FLOAT, BS_GRANT});
      data_oe_o            <= 1'b0; // Operand cycles here are reads only
    end
  end
  // Pin levels per sequencer state; floated pins rest at logic one
  always_ff @(posedge clk_i) begin
    if (!nrst_i || in_reset_r) begin
      pins_o <= PINS_RESET;
    end else begin
      pins_o                    <= PINS_RESET;
      pins_o.mem_io_select      <= 1'b1;
      pins_o.code_intack_select <= 1'b1;
      pins_o.bus_exclusive_n    <= !lock_seq_i;
      case (st_nxt)
        BS_ACK1, BS_ACK2: begin
          pins_o.cycle_status_lines <= CS_INTACK;
          pins_o.mem_io_select      <= 1'b0;
          pins_o.code_intack_select <= 1'b0;
          pins_o.bus_exclusive_n    <= 1'b0; // Pair is locked
          pins_o.address_lines      <= 24'h000000;
        end
        BS_OPND: begin
          pins_o.cycle_status_lines <= CS_MEMRD;
          pins_o.code_intack_select <= 1'b0;
          pins_o.ext_operand_ack_n  <= 1'b0;
          pins_o.address_lines      <= opnd_addr_i;
        end
        default: begin
        end
      endcase
    end
  end
  // Interrupt delivery (vector from bus or internal) and operand end
  always_ff @(posedge clk_i) begin
    if (!nrst_i || in_reset_r) begin
      int_take_o   <= 1'b0;
      int_vector_o <= 8'h00;
      opnd_done_o  <= 1'b0;
    end else begin
      int_take_o  <= 1'b0;
      opnd_done_o <= (st_r == BS_OPND) && ready_s;
      if (take_point && nmi_pend_r) begin
        int_take_o   <= 1'b1;
        int_vector_o <= NMI_VECTOR;
      end else if (st_r == BS_ACK2 && ready_s) begin
        int_take_o   <= 1'b1;
        int_vector_o <= data2_r[7:0];
      end
    end
  end

  // Coprocessor busy stalls; an error pulses while the wait stands
  always_ff @(posedge clk_i) begin
    if (!nrst_i || in_reset_r) begin
      exec_stall_o <= 1'b0;
      ext_fault_o  <= 1'b0;
    end else begin
      exec_stall_o <= coproc_wait_i && !sync2_r[SY_BUSYN];
      ext_fault_o  <= coproc_wait_i && sync2_r[SY_BUSYN] &&
                      !sync2_r[SY_ERRN] && !ext_fault_o;
    end
  end
  // Checks on the pin behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  float_first_a: assert property (
    $rose(bus_grant_ack_o) |-> !bus_oe_o && $past(!bus_oe_o))
    else $error("grant acknowledge rose before drivers floated");
  grant_release_a: assert property (
    (st_r == BS_GRANT && !sync2_r[SY_HOLD] && !in_reset_r)
      |=> !bus_grant_ack_o && bus_oe_o)
    else $error("bus not reclaimed after request dropped");
  grant_boundary_a: assert property (
    (st_r == BS_IDLE && st_nxt == BS_FLOAT)
      |-> bus_boundary_i && !lock_seq_i)
    else $error("bus granted inside a locked sequence");
  maskable_irq_mask_a: assert property (
    $rose(maskable_irq_go_r) |-> $past(if_flag_i))
    else $error("maskable request accepted with flag clear");
  intack_vector_a: assert property (
    (st_r == BS_ACK2 && ready_s && !in_reset_r && !nmi_pend_r)
      |=> int_take_o && int_vector_o == $past(data2_r[7:0]))
    else $error("vector not taken from second acknowledge");
  nmi_vector_a: assert property (
    int_take_o && $past(nmi_pend_r && take_point)
      |-> int_vector_o == 8'h02 && st_r != BS_ACK1)
    else $error("non-maskable vector wrong");
  nmi_edge_a: assert property (
    (sync2_r[SY_NMI] && !nmi_old_r && !in_reset_r) |=> nmi_pend_r)
    else $error("non-maskable edge missed");
  opnd_ack_a: assert property (
    !pins_o.ext_operand_ack_n |-> st_r == BS_OPND)
    else $error("operand acknowledge outside transfer");
  grant_float_a: assert property (
    bus_grant_ack_o |-> !ext_operand_ack_oe_o && pins_o.ext_operand_ack_n)
    else $error("operand acknowledge driven during grant");
  stall_busy_a: assert property (
    (coproc_wait_i && !sync2_r[SY_BUSYN] && !in_reset_r) |=> exec_stall_o)
    else $error("busy did not stall");
  reset_pins_a: assert property (
    in_reset_r |=> !bus_grant_ack_o && !data_oe_o && pins_o == PINS_RESET)
    else $error("pin levels wrong during reset");
  init_wait_a: assert property (
    $fell(in_reset_r) |-> !fetch_start_o [*8])
    else $error("fetch started too early after reset");
  grant_seen_c:  cover property (st_r == BS_FLOAT ##1 st_r == BS_GRANT);
  intack_pair_c: cover property (st_r == BS_ACK2 && ready_s);
  nmi_take_c:    cover property (int_take_o && int_vector_o == NMI_VECTOR);
  opnd_xfer_c:   cover property (opnd_done_o);
endmodule

// *** logic/cpu_ctl_pkg.sv ***
// Constants, pin group and state type for the processor control-pin block.
// Assumes a single 10 MHz system clock and a synchronous active-low reset.
package cpu_ctl_pkg;

  // Clock rate and processor-cycle divider (two clocks per processor cycle)
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam logic        PROC_DIV_END = 1'b1;

  // Reset pin must stay high for more than this many clocks
  localparam int unsigned RESET_HOLD_CYC = 16;
  localparam logic [4:0]  RESET_HOLD_CNT = 5'(RESET_HOLD_CYC);

  // Internal initialisation time after reset falls, in clocks
  localparam int unsigned INIT_CYC = 50;
  localparam logic [5:0]  INIT_CNT = 6'(INIT_CYC);

  // Internally supplied non-maskable vector
  localparam logic [7:0] NMI_VECTOR = 8'h02;

  // Positions of the control pins inside the synchroniser vector
  localparam int unsigned SY_HOLD  = 0;
  localparam int unsigned SY_MASKABLE_IRQ  = 1;
  localparam int unsigned SY_NMI   = 2;
  localparam int unsigned SY_OPREQ = 3;
  localparam int unsigned SY_BUSYN = 4;
  localparam int unsigned SY_ERRN  = 5;
  localparam int unsigned SY_RDYN  = 6;
  localparam int unsigned SY_RESET = 7;
  localparam int unsigned SY_W     = 8;
  // Active-low pins rest high in the synchroniser after reset
  localparam logic [7:0]  SYNC_RST = 8'h70;

  // Cycle status encodings
  localparam logic [1:0] CS_NONE   = 2'h3;
  localparam logic [1:0] CS_INTACK = 2'h0;
  localparam logic [1:0] CS_MEMRD  = 2'h1;

  // Bus-side output pins driven together
  typedef struct packed {
    logic [1:0]  cycle_status_lines;
    logic        mem_io_select;
    logic        code_intack_select;
    logic        high_byte_enable_n;
    logic        bus_exclusive_n;
    logic        ext_operand_ack_n;
    logic [23:0] address_lines;
  } pin_out_t;

  // Pin levels while reset is active
  localparam pin_out_t PINS_RESET = '{
    cycle_status_lines: 2'h3, mem_io_select: 1'b0,
    code_intack_select: 1'b0, high_byte_enable_n: 1'b1,
    bus_exclusive_n: 1'b1, ext_operand_ack_n: 1'b1,
    address_lines: 24'hffffff};

  // Bus sequencer states
  typedef enum logic [2:0] {
    BS_INIT, BS_IDLE, BS_FLOAT, BS_GRANT, BS_ACK1, BS_ACK2, BS_OPND
  } bus_state_t;

endpackage

// *** sim/cpu_ctl_far_model.sv ***
// Far side of the control pins: interrupt source and bus slave.
// Assumes the bench raises a request for one clock and sets vector and delay.
module cpu_ctl_far_model (
  // Clock
  input  wire logic                  clk_i,
  // Pins from the device
  input  wire cpu_ctl_pkg::pin_out_t pins_i,
  input  wire logic                  bus_oe_i,
  // Commands from the bench
  input  wire logic                  irq_raise_i,
  input  wire logic [7:0]            vec_i,
  input  wire logic [3:0]            dly_i,
  // Pins to the device
  output logic                       maskable_irq_o,
  output logic                       ready_n_o,
  output logic [15:0]                data_lines_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import cpu_ctl_pkg::*;

  logic [4:0] cnt_r;
  logic       busy;

  // A bus cycle runs while the device drives a real status
  assign busy = bus_oe_i && pins_i.cycle_status_lines != CS_NONE;

  initial begin
    maskable_irq_o = 1'b0;
    ready_n_o      = 1'b1;
    data_lines_o   = 16'h5a5a;
    cnt_r          = 5'h00;
  end

  // Request is held until the first acknowledge shows on the pins
  always @(posedge clk_i) begin
    if (irq_raise_i) begin
      maskable_irq_o <= 1'b1;
    end else if (busy && pins_i.cycle_status_lines == CS_INTACK) begin
      maskable_irq_o <= 1'b0;
    end
  end

  // One-clock ready pulse; gap of at least four keeps pulses apart
  // across the device's two-flop ready synchroniser
  always @(posedge clk_i) begin
    ready_n_o <= 1'b1;
    if (!busy) begin
      cnt_r <= 5'h00;
    end else if (cnt_r == 5'(dly_i) + 5'h04) begin
      cnt_r     <= 5'h00;
      ready_n_o <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // Vector only during acknowledge; otherwise the bus churns
  always @(posedge clk_i) begin
    if (busy && pins_i.cycle_status_lines == CS_INTACK) begin
      data_lines_o <= {~data_lines_o[15:8], vec_i};
    end else begin
      data_lines_o <= ~data_lines_o;
    end
  end
endmodule

// *** sim/tb_cpu_control_pin_interface.sv ***
// Self-checking bench for the processor control-pin block.
// Assumes the far-side model answers bus cycles and raises interrupts.
module tb_cpu_control_pin_interface;
  timeunit 1ns;
  timeprecision 1ns;
  import cpu_ctl_pkg::*;

  logic clk_i, nrst_i, reset_pin_i, hold_req, nmi, opreq, stall_n, fault_n;
  logic if_flag, instr_end, boundary, lock, cwait, irq_raise;
  logic [23:0] opnd_addr;
  logic [7:0]  vec, int_vector;
  logic [3:0]  dly;
  logic        maskable_irq, ready_n, grant_ack, bus_oe, ack_oe, data_oe;
  logic        core_reset, fetch_start, exec_stall, ext_fault, int_take;
  logic        opnd_done, oe_prev;
  logic [15:0] data_lines;
  pin_out_t    pins;
  int          n_errors, tests_run, n_ack, n_cyc, k, e;
  int          exp_q[$];

  cpu_ctl_pins DUT (.clk_i(clk_i), .nrst_i(nrst_i), .reset_pin_i(reset_pin_i),
    .bus_grant_request_i(hold_req), .maskable_irq_i(maskable_irq),
    .nonmaskable_irq_i(nmi), .ext_operand_req_i(opreq),
    .coproc_stall_n_i(stall_n), .coproc_fault_n_i(fault_n),
    .ready_n_i(ready_n), .data_lines_i(data_lines), .if_flag_i(if_flag),
    .instr_end_i(instr_end), .bus_boundary_i(boundary), .lock_seq_i(lock),
    .coproc_wait_i(cwait), .opnd_addr_i(opnd_addr),
    .bus_grant_ack_o(grant_ack), .pins_o(pins), .bus_oe_o(bus_oe),
    .ext_operand_ack_oe_o(ack_oe), .data_oe_o(data_oe),
    .core_reset_o(core_reset), .fetch_start_o(fetch_start),
    .exec_stall_o(exec_stall), .ext_fault_o(ext_fault),
    .int_take_o(int_take), .int_vector_o(int_vector), .opnd_done_o(opnd_done));

  cpu_ctl_far_model far (.clk_i(clk_i), .pins_i(pins), .bus_oe_i(bus_oe),
    .irq_raise_i(irq_raise), .vec_i(vec), .dly_i(dly),
    .maskable_irq_o(maskable_irq), .ready_n_o(ready_n),
    .data_lines_o(data_lines));

  task automatic check(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t ns: %s", $time, what);
    end
  endtask

  task automatic complete_run();
    $display("checks run %0d, wrong %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic pulse_end();
    instr_end = 1'b1;
    @(negedge clk_i);
    instr_end = 1'b0;
  endtask

  // Measure the quiet time from reset exit to the first fetch
  task automatic init_wait();
    int n = 0;
    for (int j = 0; j < 200 && core_reset !== 1'b0; j++) @(negedge clk_i);
    while (fetch_start !== 1'b1 && n < 200) begin
      n++;
      @(negedge clk_i);
    end
    check(n >= INIT_CYC - 2 && n <= INIT_CYC + 2, "init time");
  endtask

  task automatic nmi_edge();
    repeat (5) @(negedge clk_i);
    nmi = 1'b1;
    repeat (6) @(negedge clk_i);
    nmi = 1'b0;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Reference model: queue of expected vector plus acknowledge count
  always @(negedge clk_i) begin
    n_cyc++;
    if (n_cyc > 5000) begin
      n_errors++;
      complete_run();
    end
    if (grant_ack === 1'b1) check(!bus_oe && !oe_prev && !ack_oe, "float");
    oe_prev = bus_oe;
    if (!ready_n && bus_oe && pins.cycle_status_lines == CS_INTACK) n_ack++;
    if (int_take === 1'b1) begin
      if (exp_q.size() == 0) check(1'b0, "unexpected interrupt");
      else begin
        e = exp_q.pop_front();
        check(int_vector === 8'(e), "vector");
        check(n_ack == e / 256, "acknowledge count");
      end
      n_ack = 0;
    end
  end

  initial begin
    {nrst_i, reset_pin_i, hold_req, nmi, opreq, if_flag, instr_end} = '0;
    {lock, cwait, irq_raise, vec, dly, opnd_addr} = '0;
    {stall_n, fault_n, boundary, oe_prev} = 4'hf;
    void'($urandom(32'hbea5));
    repeat (3) @(negedge clk_i);
    check(pins === PINS_RESET && !grant_ack && bus_oe, "reset pins");
    check(ack_oe && !data_oe && core_reset, "reset enables");
    nrst_i = 1'b1;
    init_wait();
    // Grant refused inside a locked run and off a boundary
    lock = 1'b1;
    hold_req = 1'b1;
    repeat (10) @(negedge clk_i);
    check(grant_ack === 1'b0 && bus_oe === 1'b1, "locked grant");
    {lock, boundary} = 2'h0;
    repeat (10) @(negedge clk_i);
    check(grant_ack === 1'b0, "mid-cycle grant");
    boundary = 1'b1;
    for (k = 0; k < 20 && grant_ack !== 1'b1; k++) @(negedge clk_i);
    repeat (5) @(negedge clk_i);
    check(grant_ack === 1'b1, "grant held");
    hold_req = 1'b0;
    for (k = 0; k < 6 && grant_ack !== 1'b0; k++) @(negedge clk_i);
    check(grant_ack === 1'b0 && bus_oe === 1'b1, "bus reclaimed");
    // Maskable: first masked, then early ends that must not take it
    for (int r = 0; r < 4; r++) begin
      vec = 8'($urandom_range(255));
      dly = 4'($urandom_range(3));
      if_flag = (r != 0);
      exp_q.push_back(512 + int'(vec));
      irq_raise = 1'b1;
      @(negedge clk_i);
      irq_raise = 1'b0;
      pulse_end();
      repeat (3) @(negedge clk_i);
      check(pins.cycle_status_lines === CS_NONE, "early take");
      repeat (8) @(negedge clk_i);
      pulse_end();
      if (r == 0) begin
        repeat (10) @(negedge clk_i);
        check(exp_q.size() == 1 && maskable_irq, "masked");
        if_flag = 1'b1;
        pulse_end();
      end
      for (k = 0; k < 100 && exp_q.size() != 0; k++) @(negedge clk_i);
      check(exp_q.size() == 0, "maskable take");
    end
    // Non-maskable with flag clear, then no second take without an edge
    if_flag = 1'b0;
    exp_q.push_back(int'(NMI_VECTOR));
    nmi_edge();
    pulse_end();
    for (k = 0; k < 20 && exp_q.size() != 0; k++) @(negedge clk_i);
    check(exp_q.size() == 0, "nmi take");
    repeat (6) @(negedge clk_i);
    pulse_end();
    repeat (4) @(negedge clk_i);
    // Operand transfers at fast and slow ready
    for (int r = 0; r < 2; r++) begin
      opnd_addr = 24'($urandom);
      dly = 4'(r * 15);
      opreq = 1'b1;
      for (k = 0; k < 20 && pins.ext_operand_ack_n !== 1'b0; k++)
        @(negedge clk_i);
      opreq = 1'b0;
      check(pins.address_lines === opnd_addr, "operand address");
      check(pins.cycle_status_lines === CS_MEMRD, "operand status");
      for (k = 0; k < 40 && opnd_done !== 1'b1; k++) @(negedge clk_i);
      check(opnd_done === 1'b1, "operand end");
    end
    // Stall, interrupt taken while stalled, then fault
    cwait = 1'b1;
    stall_n = 1'b0;
    repeat (4) @(negedge clk_i);
    check(exec_stall === 1'b1, "stall");
    exp_q.push_back(int'(NMI_VECTOR));
    nmi_edge();
    for (k = 0; k < 20 && exp_q.size() != 0; k++) @(negedge clk_i);
    check(exp_q.size() == 0, "take while stalled");
    stall_n = 1'b1;
    repeat (4) @(negedge clk_i);
    check(exec_stall === 1'b0, "stall released");
    fault_n = 1'b0;
    for (k = 0; k < 8 && ext_fault !== 1'b1; k++) @(negedge clk_i);
    check(ext_fault === 1'b1, "extension fault");
    {cwait, fault_n} = 2'h1;
    // Reset pin: too short, then long enough
    reset_pin_i = 1'b1;
    repeat (10) @(negedge clk_i);
    reset_pin_i = 1'b0;
    repeat (4) @(negedge clk_i);
    check(core_reset === 1'b0, "short reset");
    reset_pin_i = 1'b1;
    repeat (22) @(negedge clk_i);
    check(core_reset === 1'b1 && pins === PINS_RESET, "reset entry");
    reset_pin_i = 1'b0;
    init_wait();
    complete_run();
  end
endmodule
